/* shared/fwp_pkg.sv */
// constants shared by the flash protect/status controller
package fwp_pkg;
  // flash command codes
  localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
  localparam logic [7:0] CMD_CHIP_SETUP    = 8'h30;
  localparam logic [7:0] CMD_WRITE_SETUP   = 8'h40;
  localparam logic [7:0] CMD_LOCK_SETUP    = 8'h60;
  localparam logic [7:0] CMD_CONFIRM       = 8'hD0;
  localparam logic [7:0] CMD_LOCK_BLOCK    = 8'h01;
  localparam logic [7:0] CMD_LOCK_PERM     = 8'hF1;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;

  // operation_status bit positions
  localparam int SR_READY        = 7;
  localparam int SR_ERASE_SUSP   = 6;
  localparam int SR_ERASE_ERR    = 5;
  localparam int SR_PROG_ERR     = 4;
  localparam int SR_SUPPLY_LOW   = 3;
  localparam int SR_PROG_SUSP    = 2;
  localparam int SR_PROTECT      = 1;
  localparam logic [7:0] SR_VALID_MASK = 8'hFE;

  // software register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_PINS   = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // control register fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_AUTO_BIT = 3;
  localparam int CTRL_GO_BIT   = 8;
  // pins register fields and reset values
  localparam int PIN_WP_BIT   = 0;
  localparam int PIN_RST_BIT  = 1;
  localparam int PIN_VPP_BIT  = 2;
  localparam logic [2:0] PINS_RESET = 3'h2;
  // status register fields
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_DONE_BIT   = 1;
  localparam int ST_RYBY_BIT   = 2;
  localparam int ST_SEQ_BIT    = 3;
  localparam int ST_PROT_BIT   = 4;
  localparam int ST_VPP_BIT    = 5;
  localparam int ST_FAIL_BIT   = 6;
  localparam int ST_SR_LSB     = 8;

  // bus cycle timing in clock cycles (50 MHz)
  localparam int CYC_ADDR   = 2;
  localparam int CYC_STROBE = 4;
  localparam int CYC_HOLD   = 2;

  typedef enum logic [2:0] {
    OP_BLOCK_ERASE,
    OP_CHIP_ERASE,
    OP_WRITE,
    OP_SET_LOCK,
    OP_SET_PERM,
    OP_CLEAR_LOCKS,
    OP_READ_ARRAY,
    OP_READ_STATUS
  } fwp_op_t;
endpackage : fwp_pkg

/* shared/fwp_cyc_if.sv */
// one flash bus cycle request between sequencer and cycle engine
interface fwp_cyc_if #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
);
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;

  modport seq (output req, output wr, output addr, output wdata,
               input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata,
               output done, output rdata);
endinterface : fwp_cyc_if

/* logic/fwp_cycle.sv */
// drives one asynchronous flash write or read cycle on the pins
module fwp_cycle
  import fwp_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  fwp_cyc_if.eng                 cyc,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe_o,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic                   ce_n_o,
  output logic                   we_n_o,
  output logic                   oe_n_o
);
  import fwp_pkg::*;

  typedef enum logic [1:0] {CY_IDLE, CY_ADDR, CY_STROBE, CY_HOLD} fwp_cy_t;
  fwp_cy_t    state;
  logic [3:0] cnt;
  logic       is_wr;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state   <= CY_IDLE;
      cnt     <= 4'h0;
      is_wr   <= 1'b0;
      addr_o  <= '0;
      dq_o    <= '0;
      dq_oe_o <= 1'b0;
      ce_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
      oe_n_o  <= 1'b1;
      cyc.done  <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= 1'b0;
      case (state)
        CY_IDLE: begin
          if (cyc.req) begin
            addr_o  <= cyc.addr;
            dq_o    <= cyc.wdata;
            dq_oe_o <= cyc.wr;
            is_wr   <= cyc.wr;
            ce_n_o  <= 1'b0;
            cnt     <= 4'(CYC_ADDR - 1);
            state   <= CY_ADDR;
          end
        end
        CY_ADDR: begin
          if (cnt == 4'h0) begin
            we_n_o <= ~is_wr;
            oe_n_o <= is_wr;
            cnt    <= 4'(CYC_STROBE - 1);
            state  <= CY_STROBE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        CY_STROBE: begin
          if (cnt == 4'h0) begin
            // data is latched by the device on the rising write strobe
            we_n_o    <= 1'b1;
            oe_n_o    <= 1'b1;
            cyc.rdata <= is_wr ? cyc.rdata : dq_i;
            cnt       <= 4'(CYC_HOLD - 1);
            state     <= CY_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        CY_HOLD: begin
          if (cnt == 4'h0) begin
            ce_n_o   <= 1'b1;
            dq_oe_o  <= 1'b0;
            cyc.done <= 1'b1;
            state    <= CY_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: state <= CY_IDLE;
      endcase
    end
  end
endmodule : fwp_cycle

/* logic/fwp_host.sv */
// host controller: issues flash command sequences without protect checks, reports status
module fwp_host
  import fwp_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // software port
  input  wire logic [7:0]        sw_addr_i,
  input  wire logic [31:0]       sw_wdata_i,
  input  wire logic              sw_wr_i,
  input  wire logic              sw_rd_i,
  output logic [31:0]            sw_rdata_o,
  // flash pins
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe_o,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic                   ce_n_o,
  output logic                   we_n_o,
  output logic                   oe_n_o,
  output logic                   flash_rst_n_o,
  output logic                   protect_n_o,
  output logic                   supply_en_o,
  input  wire logic              ready_busy_i
);
  import fwp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_CONFIRM, S_POLL, S_ARRAY, S_FINISH
  } fwp_state_t;

  fwp_cyc_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

  fwp_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .cyc     (cyc),
    .addr_o  (addr_o),
    .dq_o    (dq_o),
    .dq_oe_o (dq_oe_o),
    .dq_i    (dq_i),
    .ce_n_o  (ce_n_o),
    .we_n_o  (we_n_o),
    .oe_n_o  (oe_n_o)
  );

  fwp_state_t        state;
  fwp_op_t           op;
  logic              auto_array;
  logic [ADDR_W-1:0] tgt_addr;
  logic [DATA_W-1:0] tgt_data;
  logic [2:0]        pins;
  logic [7:0]        last_sr;
  logic              done_flag;
  logic              waiting;
  logic              go;
  logic              done_set;

  function automatic logic [7:0] setup_code(input fwp_op_t o);
    case (o)
      OP_BLOCK_ERASE: setup_code = CMD_ERASE_SETUP;
      OP_CHIP_ERASE:  setup_code = CMD_CHIP_SETUP;
      OP_WRITE:       setup_code = CMD_WRITE_SETUP;
      OP_SET_LOCK,
      OP_SET_PERM,
      OP_CLEAR_LOCKS: setup_code = CMD_LOCK_SETUP;
      OP_READ_ARRAY:  setup_code = CMD_READ_ARRAY;
      default:        setup_code = CMD_READ_STATUS;
    endcase
  endfunction : setup_code

  function automatic logic [DATA_W-1:0] cmd_word(input logic [7:0] c);
    cmd_word = {{(DATA_W-8){1'b0}}, c};
  endfunction : cmd_word

  // second cycle: confirm code, or the data itself for a word write
  function automatic logic [DATA_W-1:0] confirm_word(input fwp_op_t o,
                                                     input logic [DATA_W-1:0] d);
    case (o)
      OP_WRITE:    confirm_word = d;
      OP_SET_LOCK: confirm_word = cmd_word(CMD_LOCK_BLOCK);
      OP_SET_PERM: confirm_word = cmd_word(CMD_LOCK_PERM);
      default:     confirm_word = cmd_word(CMD_CONFIRM);
    endcase
  endfunction : confirm_word

  function automatic logic single_cycle(input fwp_op_t o);
    single_cycle = (o == OP_READ_ARRAY) || (o == OP_READ_STATUS);
  endfunction : single_cycle

  // one register strobe aimed at one offset
  function automatic logic reg_hit(input logic       stb,
                                   input logic [7:0] a,
                                   input logic [7:0] r);
    reg_hit = stb && (a == r);
  endfunction : reg_hit

  // a go written while busy is dropped without any indication
  assign go = reg_hit(sw_wr_i, sw_addr_i, REG_CTRL) && sw_wdata_i[CTRL_GO_BIT]
              && (state == S_IDLE);

  // pin levels the device samples when it gates each operation
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pins <= PINS_RESET;
    end else if (reg_hit(sw_wr_i, sw_addr_i, REG_PINS)) begin
      pins <= sw_wdata_i[2:0];
    end
  end

  assign protect_n_o   = pins[PIN_WP_BIT];
  assign flash_rst_n_o = pins[PIN_RST_BIT];
  assign supply_en_o   = pins[PIN_VPP_BIT];

  // operation parameters are captured only while idle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      op         <= OP_READ_ARRAY;
      auto_array <= 1'b1;
      tgt_addr   <= '0;
      tgt_data   <= '0;
    end else begin
      if (reg_hit(sw_wr_i, sw_addr_i, REG_CTRL) && state == S_IDLE) begin
        op         <= fwp_op_t'(sw_wdata_i[CTRL_OP_LSB +: 3]);
        auto_array <= sw_wdata_i[CTRL_AUTO_BIT];
      end
      if (reg_hit(sw_wr_i, sw_addr_i, REG_ADDR) && state == S_IDLE) begin
        tgt_addr <= sw_wdata_i[ADDR_W-1:0];
      end
      if (reg_hit(sw_wr_i, sw_addr_i, REG_DATA) && state == S_IDLE) begin
        tgt_data <= sw_wdata_i[DATA_W-1:0];
      end
    end
  end

  // sequencer; waiting marks a cycle already handed to the engine
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state     <= S_IDLE;
      waiting   <= 1'b0;
      cyc.req   <= 1'b0;
      cyc.wr    <= 1'b0;
      cyc.addr  <= '0;
      cyc.wdata <= '0;
      last_sr   <= 8'h00;
    end else begin
      cyc.req  <= 1'b0;
      case (state)
        S_IDLE: begin
          if (go) begin
            state <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (!waiting) begin
            cyc.req   <= 1'b1;
            cyc.wr    <= 1'b1;
            cyc.addr  <= tgt_addr;
            cyc.wdata <= cmd_word(setup_code(op));
            waiting   <= 1'b1;
          end else if (cyc.done) begin
            waiting <= 1'b0;
            if (op == OP_READ_ARRAY) begin
              state <= S_FINISH;
            end else if (op == OP_READ_STATUS) begin
              state <= S_POLL;
            end else begin
              state <= S_CONFIRM;
            end
          end
        end
        S_CONFIRM: begin
          if (!waiting) begin
            cyc.req   <= 1'b1;
            cyc.wr    <= 1'b1;
            cyc.addr  <= tgt_addr;
            cyc.wdata <= confirm_word(op, tgt_data);
            waiting   <= 1'b1;
          end else if (cyc.done) begin
            waiting <= 1'b0;
            state   <= S_POLL;
          end
        end
        S_POLL: begin
          // after the confirm the device answers every read with its status
          if (!waiting) begin
            cyc.req <= 1'b1;
            cyc.wr  <= 1'b0;
            waiting <= 1'b1;
          end else if (cyc.done) begin
            waiting <= 1'b0;
            if (cyc.rdata[SR_READY]) begin
              last_sr <= cyc.rdata[7:0] & SR_VALID_MASK;
              if (auto_array && !single_cycle(op)) begin
                state <= S_ARRAY;
              end else begin
                state <= S_FINISH;
              end
            end
          end
        end
        S_ARRAY: begin
          if (!waiting) begin
            cyc.req   <= 1'b1;
            cyc.wr    <= 1'b1;
            cyc.wdata <= cmd_word(CMD_READ_ARRAY);
            waiting   <= 1'b1;
          end else if (cyc.done) begin
            waiting <= 1'b0;
            state   <= S_FINISH;
          end
        end
        S_FINISH: begin
          state    <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // done rises in the very cycle busy falls, so no status read finds the
  // block idle with its done bit still clear
  assign done_set = (state == S_FINISH);

  // completion flag; a new completion wins over a software clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      done_flag <= 1'b0;
    end else if (done_set) begin
      done_flag <= 1'b1;
    end else if (reg_hit(sw_wr_i, sw_addr_i, REG_STATUS) && sw_wdata_i[ST_DONE_BIT]) begin
      done_flag <= 1'b0;
    end
  end

  // outcome classes decoded from the captured status
  logic seq_err;
  logic prot_err;
  logic vpp_err;
  logic op_fail;
  assign seq_err  = last_sr[SR_ERASE_ERR] && last_sr[SR_PROG_ERR];
  assign prot_err = last_sr[SR_PROTECT];
  assign vpp_err  = last_sr[SR_SUPPLY_LOW];
  assign op_fail  = last_sr[SR_ERASE_ERR] || last_sr[SR_PROG_ERR];

  logic [31:0] status_word;
  always_comb begin
    status_word               = 32'h0000_0000;
    status_word[ST_BUSY_BIT]  = (state != S_IDLE);
    status_word[ST_DONE_BIT]  = done_flag;
    status_word[ST_RYBY_BIT]  = ready_busy_i;
    status_word[ST_SEQ_BIT]   = seq_err;
    status_word[ST_PROT_BIT]  = prot_err;
    status_word[ST_VPP_BIT]   = vpp_err;
    status_word[ST_FAIL_BIT]  = op_fail;
    status_word[ST_SR_LSB +: 8] = last_sr;
  end

  // read data stands in the cycle after the read strobe only
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sw_rdata_o <= 32'h0000_0000;
    end else if (sw_rd_i) begin
      case (sw_addr_i)
        REG_CTRL:   sw_rdata_o <= {28'h000_0000, auto_array, 3'(op)};
        REG_ADDR:   sw_rdata_o <= 32'(tgt_addr);
        REG_DATA:   sw_rdata_o <= 32'(tgt_data);
        REG_PINS:   sw_rdata_o <= 32'(pins);
        REG_STATUS: sw_rdata_o <= status_word;
        default:    sw_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      sw_rdata_o <= 32'h0000_0000;
    end
  end
endmodule : fwp_host

/* verification/fwp_host_sva.sv */
// concurrent checks on the flash protect/status controller ports
module fwp_host_sva
  import fwp_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire logic [7:0]        sw_addr_i,
  input wire logic [31:0]       sw_wdata_i,
  input wire logic              sw_wr_i,
  input wire logic              sw_rd_i,
  input wire logic [31:0]       sw_rdata_o,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic              dq_oe_o,
  input wire logic              ce_n_o,
  input wire logic              we_n_o,
  input wire logic              oe_n_o,
  input wire logic              flash_rst_n_o,
  input wire logic              protect_n_o,
  input wire logic              supply_en_o,
  input wire logic              ready_busy_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire st_rd = sw_rd_i && sw_addr_i == REG_STATUS;

  property p_sel; (!we_n_o || !oe_n_o) |-> !ce_n_o && (we_n_o || oe_n_o); endproperty
  a_sel: assert property (p_sel) else $error("strobe without select");
  property p_drive; dq_oe_o |-> oe_n_o; endproperty
  a_drive: assert property (p_drive) else $error("data contention");
  property p_wlen; $fell(we_n_o) |-> !we_n_o [*4] ##1 we_n_o; endproperty
  a_wlen: assert property (p_wlen) else $error("write strobe length");
  property p_setup; $fell(we_n_o) |-> !$past(ce_n_o, 2) && $stable(dq_o); endproperty
  a_setup: assert property (p_setup) else $error("write setup");
  property p_hold; ($rose(we_n_o) || $rose(oe_n_o)) |-> !ce_n_o ##1 !ce_n_o ##1 (ce_n_o && !dq_oe_o);
  endproperty
  a_hold: assert property (p_hold) else $error("cycle hold");
  property p_rdata; !sw_rd_i |=> sw_rdata_o == 32'h0000_0000; endproperty
  a_rdata: assert property (p_rdata) else $error("stray read data");
  property p_ryby;
    st_rd && $stable(ready_busy_i) |=> sw_rdata_o[ST_RYBY_BIT] == $past(ready_busy_i)
      && !sw_rdata_o[ST_SR_LSB];
  endproperty
  a_ryby: assert property (p_ryby) else $error("ready mirror or reserved bit");
  property p_decode;
    st_rd |=> sw_rdata_o[ST_SEQ_BIT] == (sw_rdata_o[13] & sw_rdata_o[12])
      && sw_rdata_o[ST_FAIL_BIT] == (sw_rdata_o[13] | sw_rdata_o[12])
      && sw_rdata_o[ST_PROT_BIT] == sw_rdata_o[9] && sw_rdata_o[ST_VPP_BIT] == sw_rdata_o[11];
  endproperty
  a_decode: assert property (p_decode) else $error("status decode");
  property p_pins;
    sw_wr_i && sw_addr_i == REG_PINS |=>
      {supply_en_o, flash_rst_n_o, protect_n_o} == $past(sw_wdata_i[2:0]);
  endproperty
  a_pins: assert property (p_pins) else $error("pin levels");
endmodule : fwp_host_sva

/* verification/fwp_flash_model.sv */
// behavioural flash device: protection gating and operation_status
module fwp_flash_model
  import fwp_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter bit TOP    = 1'b1
) (
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [15:0]       dq_i,
  output logic      [15:0]       dq_o,
  input  wire logic              ce_n_i,
  input  wire logic              we_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              rst_n_i,
  input  wire logic              prot_n_i,
  input  wire logic              vpp_i,
  output logic                   ready_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  opst = 8'h80;
  logic [7:0]  setup = 8'h00;
  logic [15:0] lck = 16'h0000;
  logic [15:0] q = 16'h0000;
  logic        perm = 1'b0;
  logic        st = 1'b0;
  logic        bsy = 1'b0;
  logic        tog = 1'b0;
  wire  [3:0]  blk = addr_i[ADDR_W-1 -: 4];

  function automatic logic locked(input logic [3:0] b);
    return lck[b] | (!prot_n_i & (TOP ? b >= 4'he : b <= 4'h1));
  endfunction : locked

  assign ready_busy_o = !bsy;
  // a released bus shows the inverse of the last value, never a held copy
  assign dq_o = (!ce_n_i && !oe_n_i) ? q : ~q;
  always @(negedge oe_n_i) begin
    tog = ~tog;
    // busy reads carry junk below bit 7; bit 0 toggles only on ready status reads
    q = st ? {8'h00, bsy ? {1'b0, 7'($urandom)} : {opst[7:1], tog}} : 16'hc35a;
  end
  always @(negedge rst_n_i) begin
    opst = 8'h80;
    st = 1'b0;
    setup = 8'h00;
  end
  always @(posedge we_n_i) begin : wr_b
    logic [7:0] e, er, cf;
    cf = dq_i[7:0];
    e = 8'h00;
    if (!ce_n_i && rst_n_i) begin
      if (setup == 8'h00) begin
        setup = (cf inside {CMD_ERASE_SETUP, CMD_CHIP_SETUP, CMD_WRITE_SETUP, CMD_LOCK_SETUP})
          ? cf : 8'h00;
        st = cf != CMD_READ_ARRAY;
      end else begin
        er = (setup != CMD_WRITE_SETUP && (setup != CMD_LOCK_SETUP || cf == CMD_CONFIRM))
          ? 8'h20 : 8'h10;
        if (setup != CMD_WRITE_SETUP && cf != CMD_CONFIRM
            && !(setup == CMD_LOCK_SETUP && cf inside {CMD_LOCK_BLOCK, CMD_LOCK_PERM}))
          e = 8'h30;
        else if (!vpp_i)
          e = er | 8'h08;
        else if ((setup == CMD_LOCK_SETUP && cf != CMD_LOCK_PERM && perm)
            || (setup inside {CMD_ERASE_SETUP, CMD_WRITE_SETUP} && locked(blk)))
          e = er | 8'h02;
        else if (setup == CMD_LOCK_SETUP && cf == CMD_LOCK_BLOCK)
          lck[blk] = 1'b1;
        else if (setup == CMD_LOCK_SETUP && cf == CMD_LOCK_PERM)
          perm = 1'b1;
        else if (setup == CMD_LOCK_SETUP)
          lck = 16'h0000;
        setup = 8'h00;
        st = 1'b1;
        bsy = 1'b1;
        // ready moves half a nanosecond off the clock grid so no sampler races it
        #(200.5 + ($urandom % 2000));
        opst = opst | e;
        bsy = 1'b0;
      end
    end
  end
endmodule : fwp_flash_model

/* verification/tb.sv */
// self-checking bench for the flash protect/status controller
module tb;
  import fwp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 0, rst_i = 1, sw_wr_i = 0, sw_rd_i = 0;
  logic [7:0]  sw_addr_i = 0;
  logic [31:0] sw_wdata_i = 0, sw_rdata_o, rv;
  logic [20:0] addr_o;
  logic [15:0] dq_o, mdq;
  logic        dq_oe_o, ce_n_o, we_n_o, oe_n_o, flash_rst_n_o, protect_n_o, supply_en_o;
  logic        ready_busy_i;
  wire  [15:0] dq_i = dq_oe_o ? dq_o : mdq;
  int          mismatches = 0, checked = 0;

  fwp_host #(.ADDR_W(21), .DATA_W(16)) fwp_host_i (.mclk_i, .rst_i, .sw_addr_i, .sw_wdata_i,
    .sw_wr_i, .sw_rd_i, .sw_rdata_o, .addr_o, .dq_o, .dq_oe_o, .dq_i, .ce_n_o, .we_n_o,
    .oe_n_o, .flash_rst_n_o, .protect_n_o, .supply_en_o, .ready_busy_i);
  fwp_flash_model #(.ADDR_W(21), .TOP(1'b1)) fwp_flash_model_i (.addr_i(addr_o), .dq_i(dq_i),
    .dq_o(mdq), .ce_n_i(ce_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o), .rst_n_i(flash_rst_n_o),
    .prot_n_i(protect_n_o), .vpp_i(supply_en_o), .ready_busy_o(ready_busy_i));

  initial forever #10 mclk_i = ~mclk_i;

  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1;
    @(posedge mclk_i);
    sw_wr_i <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1;
    @(posedge mclk_i);
    sw_rd_i <= 0;
    #1 d = sw_rdata_o;
  endtask : rd
  // software status word expected once the device status settles at e
  function automatic logic [15:0] exp_word(input logic [7:0] e);
    return {e & SR_VALID_MASK, 1'b0, |e[5:4], e[3], e[1], &e[5:4], 3'b110};
  endfunction : exp_word
  // p = {supply, flash reset_n, protect_n}; e = device status expected after the run
  task automatic op(input fwp_op_t o, input logic [3:0] b, input logic [2:0] p,
                    input logic [7:0] e);
    int n;
    n = 0;
    // a short flash reset clears the sticky error bits between operations
    wr(REG_PINS, {29'h0, p & 3'h5});
    wr(REG_PINS, {29'h0, p});
    wr(REG_ADDR, {11'h000, b, 17'($urandom)});
    wr(REG_DATA, $urandom);
    wr(REG_CTRL, 32'h0000_0108 | o);
    rv = 32'h0000_0001;
    while (rv[ST_BUSY_BIT] !== 1'b0) begin
      rd(REG_STATUS, rv);
      n++;
      if (n > 2000) begin
        mismatches++;
        results();
      end
    end
    chk(rv[1:0], 2'b10);
    if (o != OP_READ_ARRAY)
      chk(rv[15:0], exp_word(e));
    wr(REG_STATUS, 32'h0000_0002);
    rd(REG_STATUS, rv);
    chk(rv[ST_DONE_BIT], 1'b0);
    $display("test op %0d block %0d finished", o, b);
  endtask : op

  initial begin
    rv = $urandom(77);
    repeat (12) @(posedge mclk_i);
    rst_i <= 0;
    rd(REG_PINS, rv);
    chk(rv, 32'h0000_0002);
    rd(REG_CTRL, rv);
    chk(rv, 32'h0000_000e);
    rd(8'h14, rv);
    chk(rv, 32'h0000_0000);
    op(OP_BLOCK_ERASE, 4'hf, 3'h6, 8'ha2);
    op(OP_WRITE, 4'he, 3'h6, 8'h92);
    op(OP_BLOCK_ERASE, 4'h0, 3'h6, 8'h80);
    op(OP_BLOCK_ERASE, 4'hf, 3'h7, 8'h80);
    op(OP_SET_LOCK, 4'h3, 3'h7, 8'h80);
    op(OP_BLOCK_ERASE, 4'h3, 3'h7, 8'ha2);
    op(OP_WRITE, 4'h3, 3'h6, 8'h92);
    op(OP_CHIP_ERASE, 4'h5, 3'h6, 8'h80);
    op(OP_BLOCK_ERASE, 4'h5, 3'h3, 8'ha8);
    op(OP_SET_LOCK, 4'h5, 3'h3, 8'h98);
    op(OP_CLEAR_LOCKS, 4'h5, 3'h3, 8'ha8);
    op(OP_CLEAR_LOCKS, 4'h0, 3'h7, 8'h80);
    op(OP_WRITE, 4'h3, 3'h7, 8'h80);
    op(OP_READ_STATUS, 4'h0, 3'h7, 8'h80);
    op(OP_READ_ARRAY, 4'h0, 3'h7, 8'h80);
    repeat (4) op(OP_WRITE, 4'($urandom_range(13, 2)), 3'h6, 8'h80);
    op(OP_SET_PERM, 4'h0, 3'h3, 8'h98);
    op(OP_SET_PERM, 4'h0, 3'h6, 8'h80);
    op(OP_SET_LOCK, 4'h2, 3'h7, 8'h92);
    op(OP_CLEAR_LOCKS, 4'h0, 3'h7, 8'ha2);
    results();
  end
endmodule : tb

bind fwp_host fwp_host_sva #(.DATA_W(DATA_W)) fwp_host_sva_i (.mclk_i, .rst_i, .sw_addr_i,
  .sw_wdata_i, .sw_wr_i, .sw_rd_i, .sw_rdata_o, .dq_o, .dq_oe_o, .ce_n_o, .we_n_o, .oe_n_o,
  .flash_rst_n_o, .protect_n_o, .supply_en_o, .ready_busy_i);
